/* File: hdl/srf_pkg.sv */
// Constants, types and register map of the shift, rotate and flag unit.
// Assumes an APB master on the core clock; no other package is needed.

package srf_pkg;

  localparam int unsigned SRF_ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] SRF_OFF_OPA = 8'h00;
  localparam logic [7:0] SRF_OFF_OPB = 8'h04;
  localparam logic [7:0] SRF_OFF_CTRL = 8'h08;
  localparam logic [7:0] SRF_OFF_RESULT = 8'h0C;
  localparam logic [7:0] SRF_OFF_FLAGS = 8'h10;
  localparam logic [7:0] SRF_OFF_LINK = 8'h14;
  localparam logic [7:0] SRF_OFF_STATUS = 8'h18;

  // Control register fields
  localparam int unsigned SRF_CTRL_OP_LSB = 0;
  localparam int unsigned SRF_CTRL_SETF_BIT = 4;

  // Flag positions in the condition flag register
  localparam int unsigned SRF_FLAG_N_BIT = 31;
  localparam int unsigned SRF_FLAG_Z_BIT = 30;
  localparam int unsigned SRF_FLAG_C_BIT = 29;
  localparam int unsigned SRF_FLAG_V_BIT = 28;

  // Status register fields
  localparam int unsigned SRF_STAT_OP_LSB = 0;
  localparam int unsigned SRF_STAT_CWE_BIT = 4;
  localparam int unsigned SRF_STAT_CNT_LSB = 16;

  // Return address marker bit
  localparam int unsigned SRF_LINK_MARK_BIT = 0;

  // Reset values
  localparam logic [31:0] SRF_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] SRF_RST_COUNT = 16'h0000;

  // Shift length landmarks
  localparam logic [7:0] SRF_LEN_ZERO = 8'h00;
  localparam logic [7:0] SRF_LEN_WORD = 8'h20;
  localparam logic [5:0] SRF_WORD_BITS = 6'h20;

  typedef enum logic [3:0] {
    SRF_OP_ARITH_RIGHT = 4'h0,
    SRF_OP_LOGIC_RIGHT = 4'h1,
    SRF_OP_LOGIC_LEFT = 4'h2,
    SRF_OP_ROTATE_RIGHT = 4'h3,
    SRF_OP_AND = 4'h4,
    SRF_OP_OR = 4'h5,
    SRF_OP_XOR = 4'h6,
    SRF_OP_BITCLEAR = 4'h7,
    SRF_OP_NOT = 4'h8,
    SRF_OP_AND_TEST = 4'h9,
    SRF_OP_MOVE = 4'hA
  } srf_op_t;

  typedef enum logic [1:0] {
    SRF_ST_IDLE = 2'b00,
    SRF_ST_RESP = 2'b01
  } srf_state_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } srf_flags_t;

  typedef struct packed {
    logic [31:0] data;
    logic carry;
    logic carry_we;
  } srf_shift_out_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } srf_apb_req_t;

endpackage : srf_pkg

/* File: hdl/srf_shifter.sv */
// Combinational barrel shifter with carry-out for four shift kinds.
// Assumes the caller registers the result and applies the carry.
`timescale 1ns/1ns
`default_nettype none

module srf_shifter (
  input wire logic [31:0] operand,
  input wire logic [7:0] length,
  input wire srf_pkg::srf_op_t op,
  output var srf_pkg::srf_shift_out_t shift_out
);

  logic [4:0] k;
  logic big;
  logic [63:0] wide;
  logic [4:0] below;
  logic [4:0] above;

  always_comb begin
    k = length[4:0];
    big = (length >= srf_pkg::SRF_LEN_WORD);
    wide = {operand, operand} >> k;
    below = 5'(k - 5'd1);
    above = 5'(srf_pkg::SRF_WORD_BITS - {1'b0, k});
    shift_out.data = operand;
    shift_out.carry = 1'b0;
    shift_out.carry_we = 1'b0;
    if (length != srf_pkg::SRF_LEN_ZERO) begin
      shift_out.carry_we = 1'b1;
      case (op)
        srf_pkg::SRF_OP_ARITH_RIGHT: begin
          if (big) begin
            shift_out.data = srf_pkg::SRF_RST_WORD;
            shift_out.carry = (length == srf_pkg::SRF_LEN_WORD) ?
                              operand[31] : 1'b0;
          end else begin
            shift_out.data = $signed(operand) >>> k;
            shift_out.carry = operand[below];
          end
        end
        srf_pkg::SRF_OP_LOGIC_RIGHT: begin
          if (big) begin
            shift_out.data = srf_pkg::SRF_RST_WORD;
            shift_out.carry = (length == srf_pkg::SRF_LEN_WORD) ?
                              operand[31] : 1'b0;
          end else begin
            shift_out.data = operand >> k;
            shift_out.carry = operand[below];
          end
        end
        srf_pkg::SRF_OP_LOGIC_LEFT: begin
          if (big) begin
            shift_out.data = srf_pkg::SRF_RST_WORD;
            shift_out.carry = (length == srf_pkg::SRF_LEN_WORD) ?
                              operand[0] : 1'b0;
          end else begin
            shift_out.data = operand << k;
            shift_out.carry = operand[above];
          end
        end
        srf_pkg::SRF_OP_ROTATE_RIGHT: begin
          if (k == 5'd0) begin
            shift_out.data = operand;
            shift_out.carry = operand[31];
          end else begin
            shift_out.data = wide[31:0];
            shift_out.carry = operand[below];
          end
        end
        default: begin
          shift_out.carry_we = 1'b0;
        end
      endcase
    end
  end

endmodule : srf_shifter

`default_nettype wire

/* File: hdl/srf_core.sv */
// Shift, rotate and flag unit with an APB register port.
// Assumes an APB master on mclk; one wait state on every access.
`timescale 1ns/1ns
`default_nettype none

module srf_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] result_out,
  output var srf_pkg::srf_flags_t flags_out,
  output logic [31:0] link_out
);

  // Bus side state
  srf_pkg::srf_state_t state;
  srf_pkg::srf_state_t next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  srf_pkg::srf_apb_req_t req;

  // Datapath state
  logic [31:0] opa;
  logic [31:0] next_opa;
  logic [31:0] opb;
  logic [31:0] next_opb;
  logic [31:0] next_result_out;
  srf_pkg::srf_flags_t next_flags_out;
  logic [31:0] next_link_out;
  srf_pkg::srf_op_t last_op;
  srf_pkg::srf_op_t next_last_op;
  logic last_setf;
  logic next_last_setf;
  logic last_cwe;
  logic next_last_cwe;
  logic [15:0] exec_count;
  logic [15:0] next_exec_count;

  // Decoded access
  logic mapped;
  logic wr_fire;
  logic exec;
  srf_pkg::srf_op_t exec_op;
  logic exec_setf;
  srf_pkg::srf_shift_out_t shifted;
  logic [31:0] logic_res;
  logic is_shift;

  always_comb begin
    req.addr = paddr;
    req.write = pwrite;
    req.wdata = pwdata;
  end

  always_comb begin
    case (req.addr)
      srf_pkg::SRF_OFF_OPA,
      srf_pkg::SRF_OFF_OPB,
      srf_pkg::SRF_OFF_CTRL,
      srf_pkg::SRF_OFF_RESULT,
      srf_pkg::SRF_OFF_FLAGS,
      srf_pkg::SRF_OFF_LINK,
      srf_pkg::SRF_OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Write lands only on the edge that sees pready high
  always_comb begin
    wr_fire = (state == srf_pkg::SRF_ST_RESP) && psel && penable &&
              req.write && mapped;
    exec = wr_fire && (req.addr == srf_pkg::SRF_OFF_CTRL);
    exec_op = srf_pkg::srf_op_t'(req.wdata[srf_pkg::SRF_CTRL_OP_LSB +: 4]);
    exec_setf = req.wdata[srf_pkg::SRF_CTRL_SETF_BIT];
  end

  srf_shifter u_srf_shifter (
    .operand(opa),
    .length(opb[7:0]),
    .op(exec_op),
    .shift_out(shifted)
  );

  // Bus handshake and read data
  always_comb begin
    next_state = state;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    case (state)
      srf_pkg::SRF_ST_IDLE: begin
        if (psel && penable) begin
          next_state = srf_pkg::SRF_ST_RESP;
          next_pready = 1'b1;
          next_pslverr = ~mapped;
          next_prdata = srf_pkg::SRF_RST_WORD;
          if (!req.write) begin
            case (req.addr)
              srf_pkg::SRF_OFF_OPA: next_prdata = opa;
              srf_pkg::SRF_OFF_OPB: next_prdata = opb;
              srf_pkg::SRF_OFF_CTRL: begin
                next_prdata[srf_pkg::SRF_CTRL_OP_LSB +: 4] = last_op;
                next_prdata[srf_pkg::SRF_CTRL_SETF_BIT] = last_setf;
              end
              srf_pkg::SRF_OFF_RESULT: next_prdata = result_out;
              srf_pkg::SRF_OFF_FLAGS: begin
                next_prdata[srf_pkg::SRF_FLAG_N_BIT] = flags_out.n;
                next_prdata[srf_pkg::SRF_FLAG_Z_BIT] = flags_out.z;
                next_prdata[srf_pkg::SRF_FLAG_C_BIT] = flags_out.c;
                next_prdata[srf_pkg::SRF_FLAG_V_BIT] = flags_out.v;
              end
              srf_pkg::SRF_OFF_LINK: next_prdata = link_out;
              srf_pkg::SRF_OFF_STATUS: begin
                next_prdata[srf_pkg::SRF_STAT_OP_LSB +: 4] = last_op;
                next_prdata[srf_pkg::SRF_STAT_CWE_BIT] = last_cwe;
                next_prdata[srf_pkg::SRF_STAT_CNT_LSB +: 16] = exec_count;
              end
              default: next_prdata = srf_pkg::SRF_RST_WORD;
            endcase
          end
        end
      end
      srf_pkg::SRF_ST_RESP: begin
        next_state = srf_pkg::SRF_ST_IDLE;
      end
      default: begin
        next_state = srf_pkg::SRF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= srf_pkg::SRF_ST_IDLE;
      prdata <= srf_pkg::SRF_RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Bitwise operations on the two operands
  always_comb begin
    is_shift = 1'b0;
    logic_res = opa;
    case (exec_op)
      srf_pkg::SRF_OP_ARITH_RIGHT,
      srf_pkg::SRF_OP_LOGIC_RIGHT,
      srf_pkg::SRF_OP_LOGIC_LEFT,
      srf_pkg::SRF_OP_ROTATE_RIGHT: is_shift = 1'b1;
      srf_pkg::SRF_OP_AND: logic_res = opa & opb;
      srf_pkg::SRF_OP_OR: logic_res = opa | opb;
      srf_pkg::SRF_OP_XOR: logic_res = opa ^ opb;
      srf_pkg::SRF_OP_BITCLEAR: logic_res = opa & ~opb;
      srf_pkg::SRF_OP_NOT: logic_res = ~opb;
      srf_pkg::SRF_OP_AND_TEST: logic_res = opa & opb;
      srf_pkg::SRF_OP_MOVE: logic_res = opb;
      default: logic_res = opa;
    endcase
  end

  // Datapath registers
  always_comb begin
    next_opa = opa;
    next_opb = opb;
    next_result_out = result_out;
    next_flags_out = flags_out;
    next_link_out = link_out;
    next_last_op = last_op;
    next_last_setf = last_setf;
    next_last_cwe = last_cwe;
    next_exec_count = exec_count;
    if (wr_fire) begin
      case (req.addr)
        srf_pkg::SRF_OFF_OPA: next_opa = req.wdata;
        srf_pkg::SRF_OFF_OPB: next_opb = req.wdata;
        srf_pkg::SRF_OFF_FLAGS: begin
          next_flags_out.n = req.wdata[srf_pkg::SRF_FLAG_N_BIT];
          next_flags_out.z = req.wdata[srf_pkg::SRF_FLAG_Z_BIT];
          next_flags_out.c = req.wdata[srf_pkg::SRF_FLAG_C_BIT];
          next_flags_out.v = req.wdata[srf_pkg::SRF_FLAG_V_BIT];
        end
        srf_pkg::SRF_OFF_LINK: begin
          next_link_out = req.wdata;
          next_link_out[srf_pkg::SRF_LINK_MARK_BIT] = 1'b1;
        end
        default: begin
          next_opa = opa;
        end
      endcase
    end
    if (exec) begin
      next_last_op = exec_op;
      next_last_setf = exec_setf;
      next_exec_count = 16'(exec_count + 16'h0001);
      next_last_cwe = 1'b0;
      if (is_shift) begin
        next_result_out = shifted.data;
        next_flags_out.n = shifted.data[31];
        next_flags_out.z = (shifted.data == srf_pkg::SRF_RST_WORD);
        if (shifted.carry_we) begin
          next_flags_out.c = shifted.carry;
          next_last_cwe = 1'b1;
        end
      end else begin
        if (exec_op != srf_pkg::SRF_OP_AND_TEST) begin
          next_result_out = logic_res;
        end
        if (exec_setf || exec_op == srf_pkg::SRF_OP_AND_TEST) begin
          next_flags_out.n = logic_res[31];
          next_flags_out.z = (logic_res == srf_pkg::SRF_RST_WORD);
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opa <= srf_pkg::SRF_RST_WORD;
      opb <= srf_pkg::SRF_RST_WORD;
      result_out <= srf_pkg::SRF_RST_WORD;
      flags_out <= '0;
      link_out <= srf_pkg::SRF_RST_WORD;
      last_op <= srf_pkg::SRF_OP_ARITH_RIGHT;
      last_setf <= 1'b0;
      last_cwe <= 1'b0;
      exec_count <= srf_pkg::SRF_RST_COUNT;
    end else begin
      opa <= next_opa;
      opb <= next_opb;
      result_out <= next_result_out;
      flags_out <= next_flags_out;
      link_out <= next_link_out;
      last_op <= next_last_op;
      last_setf <= next_last_setf;
      last_cwe <= next_last_cwe;
      exec_count <= next_exec_count;
    end
  end

endmodule : srf_core

`default_nettype wire

/* File: verif/srf_core_asserts.sv */
// Port-level checker for the shift, rotate and flag unit.
// Assumes it is bound to srf_core and watches only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module srf_core_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] result_out,
  input wire srf_pkg::srf_flags_t flags_out,
  input wire logic [31:0] link_out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic done;
  logic wr_ctrl;
  logic [31:0] wdata_q;
  logic [31:0] next_wdata_q;

  assign done = psel && penable && pready;
  assign wr_ctrl = done && pwrite && (paddr == srf_pkg::SRF_OFF_CTRL);

  // Data of the last completed transfer, seen one cycle later
  always_comb begin
    next_wdata_q = done ? pwdata : wdata_q;
  end
  always_ff @(posedge mclk) begin
    wdata_q <= next_wdata_q;
  end

  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  unmapped_err_a: assert property (done && paddr > 8'h18 |-> pslverr)
    else $error("unmapped address not refused");
  link_mark_a: assert property (
    done && pwrite && paddr == srf_pkg::SRF_OFF_LINK
    |=> link_out == {wdata_q[31:1], 1'b1})
    else $error("stored return address low bit not forced");
  flags_move_a: assert property (
    done && pwrite && paddr == srf_pkg::SRF_OFF_FLAGS
    |=> flags_out == wdata_q[31:28])
    else $error("flag move did not load all four flags");
  shift_nz_a: assert property (
    wr_ctrl && pwdata[3:0] <= 4'h3
    |=> flags_out.z == (result_out == 32'h0000_0000)
        && flags_out.n == result_out[31])
    else $error("shift zero or negative flag wrong");
  shift_keep_v_a: assert property (
    wr_ctrl && pwdata[3:0] <= 4'h3 |=> $stable(flags_out.v))
    else $error("shift touched overflow flag");
  logic_keep_cv_a: assert property (
    wr_ctrl && pwdata[3:0] >= 4'h4 && pwdata[3:0] <= 4'h9
    |=> $stable({flags_out.c, flags_out.v}))
    else $error("logic op touched carry or overflow");
  test_keep_res_a: assert property (
    wr_ctrl && pwdata[3:0] == 4'h9 |=> $stable(result_out))
    else $error("and-test changed the result");

  cover property (wr_ctrl && pwdata[3:0] == 4'h3);
  cover property (wr_ctrl && pwdata[3:0] == 4'h9);
  cover property (done && pslverr);
endmodule : srf_core_asserts

bind srf_core srf_core_asserts u_srf_core_asserts (
  .mclk(mclk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .result_out(result_out),
  .flags_out(flags_out),
  .link_out(link_out)
);

`default_nettype wire

/* File: verif/tb_srf_core.sv */
// Self-checking bench for the shift, rotate and flag unit.
// Assumes srf_core and srf_pkg are compiled first; APB master is the bench.
`timescale 1ns/1ns
`default_nettype none

module tb_srf_core;
  logic mclk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic e;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] result_out;
  logic [31:0] link_out;
  logic [31:0] q;
  srf_pkg::srf_flags_t flags_out;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  srf_core u_srf_core (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .result_out(result_out),
    .flags_out(flags_out),
    .link_out(link_out)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Whole run needs under two thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One idle cycle after each transfer drops psel and penable before the next setup phase
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    check({31'h0000_0000, pready}, 32'h0000_0001);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // Expected {carry, result} of the four shift kinds
  function automatic logic [32:0] ref_op(input logic [3:0] op,
      input logic [31:0] a, input logic [7:0] len, input logic cin);
    int n;
    int m;
    logic [31:0] r;
    logic c;
    n = len;
    m = n % 32;
    r = a;
    c = cin;
    if (n != 0) begin
      c = (n >= 33) ? 1'b0 : a[n-1];
      case (op)
        4'h0: r = (n >= 32) ? 32'h0000_0000 : 32'($signed(a) >>> n);
        4'h1: r = (n >= 32) ? 32'h0000_0000 : a >> n;
        4'h2: begin
          r = (n >= 32) ? 32'h0000_0000 : a << n;
          c = (n >= 33) ? 1'b0 : a[32-n];
        end
        default: begin
          r = (m == 0) ? a : (a >> m) | (a << (32 - m));
          c = (m == 0) ? a[31] : a[m-1];
        end
      endcase
    end
    return {c, r};
  endfunction : ref_op

  task automatic exec(input logic [3:0] op, input logic [31:0] a,
                      input logic [31:0] b, input logic setf);
    apb(1'b1, srf_pkg::SRF_OFF_OPA, a);
    apb(1'b1, srf_pkg::SRF_OFF_OPB, b);
    apb(1'b1, srf_pkg::SRF_OFF_CTRL, {27'h000_0000, setf, op});
  endtask : exec

  task automatic t_reset;
    logic [7:0] regs [4];
    regs = '{srf_pkg::SRF_OFF_RESULT, srf_pkg::SRF_OFF_FLAGS,
             srf_pkg::SRF_OFF_LINK, srf_pkg::SRF_OFF_STATUS};
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0000_0000);
      check(q, 32'h0000_0000);
      check({31'h0000_0000, e}, 32'h0000_0000);
    end
  endtask : t_reset

  // Every shift kind across zero, word and over-word lengths
  task automatic t_shift;
    logic [7:0] lens [10];
    logic [31:0] ops [2];
    logic [31:0] b;
    logic [32:0] x;
    logic cin;
    logic [7:0] len;
    logic [3:0] ef;
    lens = '{8'h00, 8'h01, 8'h03, 8'h1F, 8'h20, 8'h21, 8'h28, 8'h3F,
             8'h40, 8'hFF};
    ops = '{32'h8765_4321, 32'h4000_0003};
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 20; i++) begin
        cin = i[0] ^ k[0];
        len = lens[i % 10];
        b = {24'hAB_CDEF, len};
        apb(1'b1, srf_pkg::SRF_OFF_FLAGS, {2'b00, cin, ~cin, 28'h000_0000});
        x = ref_op(4'(k), ops[i / 10], len, cin);
        exec(4'(k), ops[i / 10], b, 1'b1);
        check(result_out, x[31:0]);
        check(32'(flags_out.c), 32'(x[32]));
        ef = {x[31], x[31:0] == 32'h0000_0000, x[32], ~cin};
        check({28'h000_0000, flags_out}, {28'h000_0000, ef});
        apb(1'b0, srf_pkg::SRF_OFF_STATUS, 32'h0000_0000);
        check(32'(q[4:0]), {27'h000_0000, len != 8'h00, 4'(k)});
      end
    end
  endtask : t_shift

  task automatic t_logic;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [31:0] prev;
    logic [3:0] ef;
    a = 32'hF0F0_00FF;
    b = 32'h0F0F_FF00;
    for (int k = 4; k <= 10; k++) begin
      case (k)
        4: r = a & b;
        5: r = a | b;
        6: r = a ^ b;
        7: r = a & ~b;
        8: r = ~b;
        9: r = a & b;
        default: r = b;
      endcase
      prev = result_out;
      // Preset N and Z opposite to what the op must give
      apb(1'b1, srf_pkg::SRF_OFF_FLAGS,
          {~r[31], r != 32'h0000_0000, 2'b11, 28'h000_0000});
      exec(4'(k), a, b, 1'b1);
      ef = {r[31], r == 32'h0000_0000, 2'b11};
      check({28'h000_0000, flags_out}, {28'h000_0000, ef});
      check(result_out, (k == 9) ? prev : r);
    end
    apb(1'b1, srf_pkg::SRF_OFF_FLAGS, 32'h5000_0000);
    exec(4'h5, a, b, 1'b0);
    check({28'h000_0000, flags_out}, 32'h0000_0005);
  endtask : t_logic

  task automatic t_regs;
    logic [31:0] prev;
    apb(1'b1, srf_pkg::SRF_OFF_LINK, 32'h1234_5678);
    apb(1'b0, srf_pkg::SRF_OFF_LINK, 32'h0000_0000);
    check(q, 32'h1234_5679);
    check(link_out, 32'h1234_5679);
    apb(1'b1, srf_pkg::SRF_OFF_FLAGS, 32'hA000_0000);
    apb(1'b0, srf_pkg::SRF_OFF_FLAGS, 32'h0000_0000);
    check(q, 32'hA000_0000);
    check({28'h000_0000, flags_out}, 32'h0000_000A);
    prev = result_out;
    apb(1'b1, srf_pkg::SRF_OFF_RESULT, 32'hFFFF_FFFF);
    apb(1'b0, srf_pkg::SRF_OFF_RESULT, 32'h0000_0000);
    check(q, prev);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check(q, 32'h0000_0000);
    check({31'h0000_0000, e}, 32'h0000_0001);
    apb(1'b1, 8'h40, 32'h0000_0001);
    check({31'h0000_0000, e}, 32'h0000_0001);
  endtask : t_regs

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_shift();
    t_logic();
    t_regs();
    results();
  end
endmodule : tb_srf_core

`default_nettype wire
